// file: dv/tb_top.sv
// Self-checking bench for the watchdog timer.
`include "watchdog_defines.svh"
`define CHECK(name, exp_v, got_v) begin total_checks++; if ((got_v) !== (exp_v)) begin \
err_total++; $display("[FAIL] %s exp %h got %h", name, exp_v, got_v); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [12:0] paddr = 13'h0;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic pready, pslverr, req, er;
   logic clk_lp = 1'h0, clk_ir = 1'h0, clk_ex = 1'h0, dbg = 1'h0, stp = 1'h0;
   int err_total = 0, total_checks = 0;
   logic [7:0] cfg [11] = '{8'hc4, 8'hc8, 8'hcc, 8'hc4, 8'he4, 8'hc4, 8'hd4, 8'hc0,
      8'h04, 8'h44, 8'h84};
   int tmo [11] = '{32, 256, 1024, 0, 32, 0, 32, 0, 320, 640, 1280};
   logic [1:0] mode [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
   watchdog_timer_service u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_power_oscillator(clk_lp), .internal_reference_clock(clk_ir),
      .external_oscillator_clock(clk_ex), .debug_mode(dbg), .stop_mode(stp),
      .system_reset_request(req));
   initial forever #2.5 pclk = ~pclk;
   initial forever #25 clk_lp = ~clk_lp;
   initial forever #50 clk_ir = ~clk_ir;
   initial forever #100 clk_ex = ~clk_ex;
   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rst();
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
   endtask
   task automatic svc();
      apb(1'h1, `SERVICE_OFFSET, 32'h55);
      apb(1'h1, `SERVICE_OFFSET, 32'haa);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
      `CHECK("request idle", 1'h0, req)
   endtask
   task automatic fire(input int t);
      int n;
      n = 0;
      while (req !== 1'h1 && n < t + t / 8 + 12) begin
         @(posedge pclk);
         n++;
      end
      `CHECK("request time", 1'h1, req === 1'h1 && n >= t - t / 8 - 12)
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #300us;
      err_total++;
      test_done();
   end
   initial begin
      rst();
      apb(1'h0, `CONTROL_OFFSET, 32'h0);
      `CHECK("control reset", 32'h0c, rd)
      `CHECK("control read ok", 1'h0, er)
      apb(1'h0, `SERVICE_OFFSET, 32'h0);
      `CHECK("service read", 1'h1, er)
      apb(1'h0, 13'h0000, 32'h0);
      `CHECK("unmapped read", 1'h1, er)
      apb(1'h1, `CONTROL_OFFSET, 32'hc4);
      apb(1'h1, `CONTROL_OFFSET, 32'h00);
      apb(1'h0, `CONTROL_OFFSET, 32'h0);
      `CHECK("write once", 32'hc4, rd)
      rst();
      apb(1'h1, `CONTROL_OFFSET, 32'hc4);
      repeat (8) begin
         idle(16);
         svc();
      end
      fire(32);
      rst();
      apb(1'h1, `SERVICE_OFFSET, 32'h12);
      fire(0);
      apb(1'h0, `STATUS_OFFSET, 32'h0);
      `CHECK("status bad value", 8'h10, rd[7:0])
      rst();
      apb(1'h1, `CONTROL_OFFSET, 32'hc7);
      apb(1'h1, `SERVICE_OFFSET, 32'h55);
      fire(0);
      apb(1'h0, `STATUS_OFFSET, 32'h0);
      `CHECK("status early", 8'h23, rd[7:0])
      rst();
      apb(1'h1, `CONTROL_OFFSET, 32'hc7);
      idle(6300);
      svc();
      fire(8192);
      for (int i = 0; i < 11; i++) begin
         rst();
         dbg <= mode[i][0];
         stp <= mode[i][1];
         apb(1'h1, `CONTROL_OFFSET, {24'h0, cfg[i]});
         if (tmo[i] == 0) idle(1500);
         else fire(tmo[i]);
      end
      test_done();
   end
endmodule

// file: dv/watchdog_assertions.sv
// Checker on the watchdog timer ports.
`include "watchdog_defines.svh"
module watchdog_checker #(
   parameter int COUNT_WIDTH = `COUNT_BITS
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_BITS-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Sources, modes and reset request.
   input wire logic low_power_oscillator,
   input wire logic internal_reference_clock,
   input wire logic external_oscillator_clock,
   input wire logic debug_mode,
   input wire logic stop_mode,
   input wire logic system_reset_request
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic locked;
   logic [7:0] ctl;
   logic [7:0] quiet;
   wire acc = psel && penable;
   wire ctl_wr = acc && pwrite && paddr == `CONTROL_OFFSET && !locked;
   wire ctl_rd = acc && !pwrite && paddr == `CONTROL_OFFSET;
   wire srv = acc && paddr == `SERVICE_OFFSET;
   wire bad = srv && pwrite && pwdata[7:0] != `UNLOCK_FIRST && pwdata[7:0] != `UNLOCK_SECOND;
   wire hold = (debug_mode && !ctl[5]) || (stop_mode && !ctl[4]);
   wire [1:0] tsel = ctl[3:2];
   // Tracks the control value that the first write locks in.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked <= 1'h0;
         ctl <= `CONTROL_RESET;
      end else if (ctl_wr) begin
         locked <= 1'h1;
         ctl <= pwdata[7:0];
      end
   end
   // Counts cycles since the counter was last cleared by configuration.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quiet <= 8'h00;
      else if (ctl_wr) quiet <= 8'h00;
      else if (quiet != 8'hff) quiet <= quiet + 8'h01;
   end
   chk_service_read: assert property (srv && !pwrite |-> pslverr)
   else $error("service read accepted");
   chk_control_read: assert property (ctl_rd |-> !pslverr && prdata == {24'h0, $past(ctl)})
   else $error("control read wrong");
   chk_reset_value: assert property (ctl_rd && !$past(locked) |-> prdata[7:0] == 8'h0c)
   else $error("control reset value wrong");
   chk_bad_value: assert property (bad |=> system_reset_request)
   else $error("bad service value ignored");
   chk_request_held: assert property (system_reset_request |=> system_reset_request)
   else $error("reset request dropped");
   chk_timeout_off: assert property ($rose(system_reset_request) && !$past(srv) |-> $past(tsel) != 2'h0)
   else $error("request while disabled");
   chk_timeout_floor: assert property ($rose(system_reset_request) && !$past(srv) |-> quiet >= 8'h1e)
   else $error("timeout too early");
   chk_mode_hold: assert property (hold && $past(hold) && !srv |=> !$rose(system_reset_request))
   else $error("request while held");
   cover property (bad);
   cover property (ctl_rd && locked);
   cover property (hold ##1 hold);
endmodule
bind watchdog_timer_service watchdog_checker #(.COUNT_WIDTH(COUNT_WIDTH)) u_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .low_power_oscillator(low_power_oscillator),
   .internal_reference_clock(internal_reference_clock),
   .external_oscillator_clock(external_oscillator_clock), .debug_mode(debug_mode),
   .stop_mode(stop_mode), .system_reset_request(system_reset_request));

// file: inc/watchdog_defines.svh
// Register offsets, field positions, reset values and timeout exponents of the watchdog.
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH

`define ADDR_BITS 13
`define CONTROL_OFFSET 13'h1100
`define SERVICE_OFFSET 13'h1104
`define STATUS_OFFSET 13'h1108

`define CONTROL_RESET 8'h0c
`define CONTROL_SOURCE_HI 7
`define CONTROL_SOURCE_LO 6
`define CONTROL_DEBUG_BIT 5
`define CONTROL_STOP_BIT 4
`define CONTROL_TIMEOUT_HI 3
`define CONTROL_TIMEOUT_LO 2
`define CONTROL_RANGE_BIT 1
`define CONTROL_WINDOW_BIT 0

`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'haa

`define COUNT_BITS 18
`define SHIFT_SHORT_1 5'd5
`define SHIFT_SHORT_2 5'd8
`define SHIFT_SHORT_3 5'd10
`define SHIFT_LONG_1 5'd13
`define SHIFT_LONG_2 5'd16
`define SHIFT_LONG_3 5'd18

`define STATUS_LOCKED_BIT 0
`define STATUS_ARMED_BIT 1
`define STATUS_WINDOW_BIT 2
`define STATUS_TIMEOUT_BIT 3
`define STATUS_SERVICE_ERR_BIT 4
`define STATUS_EARLY_BIT 5
`define STATUS_COUNT_LO 8
`define STATUS_COUNT_HI 25

`define SOURCE_COUNT 3

`endif

// file: inc/watchdog_pkg.sv
// Types shared by the watchdog modules.
package watchdog_pkg;

   typedef struct packed {
      logic [1:0] counter_clock_source;
      logic run_in_debug;
      logic run_in_stop;
      logic [1:0] timeout_select;
      logic timeout_range;
      logic windowed_enable;
   } control_type;

   typedef enum logic [1:0] {
      source_low_power,
      source_internal_reference,
      source_external_oscillator,
      source_bus
   } clock_source_type;

   typedef enum {
      await_first,
      await_second
   } service_state_type;

   typedef struct packed {
      logic timeout;
      logic bad_value;
      logic early_service;
   } reset_cause_type;

endpackage

// file: rtl/watchdog_tick_sync.sv
// Synchronises the slow source clocks and turns each rising edge into a one-cycle tick.
`include "watchdog_defines.svh"

module watchdog_tick_sync #(
   parameter int SOURCES = `SOURCE_COUNT
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Raw source clocks and their ticks.
   input wire logic [SOURCES-1:0] source_clock,
   output logic [SOURCES-1:0] source_tick
);

   genvar i;

   generate
      for (i = 0; i < SOURCES; i++) begin : gen_source
         logic meta;
         logic stable;
         logic previous;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta <= 1'b0;
               stable <= 1'b0;
               previous <= 1'b0;
            end else begin
               meta <= source_clock[i];
               stable <= meta;
               previous <= stable;
            end
         end

         assign source_tick[i] = stable & ~previous;
      end
   endgenerate

endmodule

// file: rtl/watchdog_timer_service.sv
// Watchdog timer with write-once control, unlock service register and APB access.
//
// Behaviour
// RQ1: Only the first control write after reset is taken; it also clears the counter.
// RQ2: Bits 7-6 pick counter clock: low-power, internal reference, external, bus.
// RQ3: Run-in-debug bit 5 clear holds counter reset during debug mode.
// RQ4: Run-in-stop bit 4 clear holds counter reset during stop mode.
// RQ5: Timeout field 0 disables; 1..3 give 2^5/8/10 or 2^13/16/18 cycles.
// RQ6: Range bit 1 picks short range when 0, long range when 1.
// RQ7: Windowed long range: service before final quarter forces reset at once.
// RQ8: Service register is write-only; reads answer with a bus error.
// RQ9: Writing 0x55 then 0xaa clears counter and restarts the timeout.
// RQ10: Any other value written to service register forces an immediate reset.
// RQ11: Counter reaching the selected timeout forces a system reset.
// RQ12: After reset watchdog runs on low-power clock with longest short timeout.
// RQ13: Counter advances once per synchronised source clock edge, compared to timeout.
`include "watchdog_defines.svh"

module watchdog_timer_service
   import watchdog_pkg::*;
#(
   parameter int COUNT_WIDTH = `COUNT_BITS
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_BITS-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counter source clocks.
   input wire logic low_power_oscillator,
   input wire logic internal_reference_clock,
   input wire logic external_oscillator_clock,
   // Chip mode.
   input wire logic debug_mode,
   input wire logic stop_mode,
   // Reset request.
   output logic system_reset_request
);

   // Configuration and counter state.
   control_type control;
   logic locked;
   service_state_type service_state;
   logic [COUNT_WIDTH-1:0] counter;
   reset_cause_type cause;

   // Counter control.
   logic [`SOURCE_COUNT-1:0] source_tick;
   logic count_tick;
   logic held;
   logic enabled;
   logic [4:0] shift;
   logic [COUNT_WIDTH:0] limit;
   logic [COUNT_WIDTH:0] window_start;
   logic [COUNT_WIDTH:0] next_count;
   logic window_open;
   logic windowed;

   // Bus decode and service checks.
   logic setup;
   logic access;
   logic hit_control;
   logic hit_service;
   logic hit_status;
   logic mapped;
   logic control_write;
   logic service_write;
   logic [7:0] service_value;
   logic service_done;
   logic bad_value;
   logic early_service;
   logic timeout;
   logic [31:0] next_rdata;

   // Derived controls and the status word.
   logic [31:0] status_word;
   logic restart;
   logic counting;
   logic count_done;
   logic debug_hold;
   logic stop_hold;
   logic fault;
   logic service_first;
   logic service_second;

   // Address decode and bus phases.
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign hit_control = (paddr == `CONTROL_OFFSET);
   assign hit_service = (paddr == `SERVICE_OFFSET);
   assign hit_status = (paddr == `STATUS_OFFSET);
   assign mapped = hit_control | hit_service | hit_status;

   // Every transfer completes in its first access cycle.
   assign pready = 1'b1;

   // Reading the service register, touching an unmapped word or writing the read-only status word is refused.
   always_comb begin
      pslverr = 1'b0;
      if (access) begin
         if (!mapped) begin
            pslverr = 1'b1;
         end else if (hit_service && !pwrite) begin
            pslverr = 1'b1; // [RQ8]
         end else if (hit_status && pwrite) begin
            pslverr = 1'b1;
         end
      end
   end

   // Register write strobes and the service byte.
   assign control_write = access & pwrite & hit_control;
   assign service_write = access & pwrite & hit_service;
   assign service_value = pwdata[7:0];

   // Source clock synchronisers.
   watchdog_tick_sync #(
      .SOURCES(`SOURCE_COUNT)
   ) u_tick_sync (
      .pclk(pclk),
      .presetn(presetn),
      .source_clock({external_oscillator_clock, internal_reference_clock,
                     low_power_oscillator}),
      .source_tick(source_tick)
   );

   // Counter clock selection.
   always_comb begin
      case (clock_source_type'(control.counter_clock_source))
         source_low_power: begin
            count_tick = source_tick[0]; // [RQ2] [RQ13]
         end
         source_internal_reference: begin
            count_tick = source_tick[1]; // [RQ2] [RQ13]
         end
         source_external_oscillator: begin
            count_tick = source_tick[2]; // [RQ2] [RQ13]
         end
         source_bus: begin
            count_tick = 1'b1; // [RQ2]
         end
         default: begin
            count_tick = 1'b0;
         end
      endcase
   end

   // Timeout length from the timeout field and the range bit.
   always_comb begin
      case ({control.timeout_range, control.timeout_select})
         3'b001: begin
            shift = `SHIFT_SHORT_1; // [RQ5] [RQ6]
         end
         3'b010: begin
            shift = `SHIFT_SHORT_2; // [RQ5] [RQ6]
         end
         3'b011: begin
            shift = `SHIFT_SHORT_3; // [RQ5] [RQ6]
         end
         3'b101: begin
            shift = `SHIFT_LONG_1; // [RQ5] [RQ6]
         end
         3'b110: begin
            shift = `SHIFT_LONG_2; // [RQ5] [RQ6]
         end
         3'b111: begin
            shift = `SHIFT_LONG_3; // [RQ5] [RQ6]
         end
         default: begin
            shift = 5'd0;
         end
      endcase
   end

   // Timeout count as a power of two, one bit wider than the counter.
   assign limit = (COUNT_WIDTH+1)'(1) << shift;

   // The window opens once three quarters of the timeout have passed.
   assign window_start = limit - (limit >> 2); // [RQ7]
   assign window_open = ({1'b0, counter} >= window_start);
   assign windowed = control.windowed_enable & control.timeout_range; // [RQ7]

   // Field value zero switches the counter, its timeout and the window check off.
   assign enabled = (control.timeout_select != 2'b00); // [RQ5]

   // Debug and stop modes hold the counter at zero unless allowed to run.
   assign debug_hold = debug_mode & ~control.run_in_debug; // [RQ3]
   assign stop_hold = stop_mode & ~control.run_in_stop; // [RQ4]
   assign held = debug_hold | stop_hold;

   // Next count, one bit wider so that the last step of the period is seen.
   assign next_count = {1'b0, counter} + (COUNT_WIDTH+1)'(1);

   // Service value checks.
   assign service_first = (service_value == `UNLOCK_FIRST);
   assign service_second = (service_value == `UNLOCK_SECOND);
   assign bad_value = service_write & ~service_first & ~service_second; // [RQ10]
   assign early_service = service_write & enabled & windowed & ~window_open; // [RQ7]
   assign service_done = service_write & service_second
                       & (service_state == await_second); // [RQ9]

   // Counting steps and the last step of the period.
   assign counting = enabled & ~held & count_tick; // [RQ13]
   assign count_done = (next_count >= limit);
   assign timeout = counting & count_done; // [RQ11]
   assign fault = timeout | bad_value | early_service;

   // Every event that restarts the timeout period from zero.
   always_comb begin
      restart = 1'b0;
      if (control_write && !locked) begin
         restart = 1'b1; // [RQ1]
      end
      if (!enabled || held) begin
         restart = 1'b1; // [RQ3] [RQ4] [RQ5]
      end
      if (service_done) begin
         restart = 1'b1; // [RQ9]
      end
   end

   // Write-once control register with its lock flag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= control_type'(`CONTROL_RESET); // [RQ12]
      end else if (control_write && !locked) begin
         control <= control_type'(pwdata[7:0]); // [RQ1]
      end
   end

   // Any control write, taken or not, keeps the register closed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked <= 1'b0;
      end else if (control_write) begin
         locked <= 1'b1; // [RQ1]
      end
   end

   // Unlock sequence tracker.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         service_state <= await_first;
      end else if (service_write) begin
         case (service_state)
            await_first: begin
               if (service_value == `UNLOCK_FIRST) begin
                  service_state <= await_second; // [RQ9]
               end
            end
            await_second: begin
               if (service_value != `UNLOCK_FIRST) begin
                  service_state <= await_first; // [RQ9]
               end
            end
            default: begin
               service_state <= await_first;
            end
         endcase
      end
   end

   // Watchdog counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter <= '0;
      end else if (restart) begin
         counter <= '0; // [RQ1] [RQ9]
      end else if (counting && !count_done) begin
         counter <= next_count[COUNT_WIDTH-1:0]; // [RQ13]
      end
   end

   // Reset causes stay set until the system reset arrives.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause <= '0;
      end else begin
         if (timeout) begin
            cause.timeout <= 1'b1; // [RQ11]
         end
         if (bad_value) begin
            cause.bad_value <= 1'b1; // [RQ10]
         end
         if (early_service) begin
            cause.early_service <= 1'b1; // [RQ7]
         end
      end
   end

   // The reset request stays up until the system reset arrives.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_reset_request <= 1'b0;
      end else if (fault) begin
         system_reset_request <= 1'b1; // [RQ7] [RQ10] [RQ11]
      end
   end

   // Status word: lock, unlock progress, window, reset causes and the count.
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`STATUS_LOCKED_BIT] = locked;
      status_word[`STATUS_ARMED_BIT] = (service_state == await_second);
      status_word[`STATUS_WINDOW_BIT] = window_open;
      status_word[`STATUS_TIMEOUT_BIT] = cause.timeout;
      status_word[`STATUS_SERVICE_ERR_BIT] = cause.bad_value;
      status_word[`STATUS_EARLY_BIT] = cause.early_service;
      status_word[`STATUS_COUNT_HI:`STATUS_COUNT_LO] = counter;
   end

   // Read data is prepared during the setup cycle.
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_control) begin
         next_rdata[7:0] = control;
      end else if (hit_status) begin
         next_rdata = status_word;
      end
   end

   // The read register holds its word through the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= next_rdata; // [RQ8]
      end else if (setup) begin
         prdata <= 32'h0000_0000;
      end
   end

endmodule
